// >>> include/motion_defines.svh
// Constants of the motion command interpreter: frame codes, status codes,
// register offsets and reset values. Definitions only.
`ifndef MOTION_DEFINES_SVH
`define MOTION_DEFINES_SVH

// Frame layout
`define FRAME_LEN 4'h9
`define FRAME_LAST 4'h8
`define FB_ADDR 4'h0
`define FB_CODE 4'h1
`define FB_TYPE 4'h2
`define FB_MOTOR 4'h3
`define FB_VAL3 4'h4
`define FB_SUM 4'h8

// Instruction codes
`define CODE_SPIN_RIGHT 8'h01
`define CODE_SPIN_LEFT 8'h02
`define CODE_HALT 8'h03
`define CODE_GOTO_IDX 8'h2f
`define CODE_LEFT_ACCU 8'h32
`define CODE_RIGHT_ACCU 8'h33
`define CODE_LEFT_IDX 8'h34

// Move types
`define TYPE_FIXED 8'h00
`define TYPE_OFFSET 8'h01
`define TYPE_STORED 8'h02

// Reply status codes
`define ST_OK 8'h64
`define ST_BAD_SUM 8'h01
`define ST_BAD_CMD 8'h02
`define ST_BAD_TYPE 8'h03
`define ST_BAD_VALUE 8'h04

// Axis count and target-velocity parameter number
`define AXES 2'h3
`define PARAM_TARGET_VEL 8'h02

// Register offsets (byte addresses)
`define OFS_ACCU 8'h00
`define OFS_XREG 8'h04
`define OFS_MODADDR 8'h08
`define OFS_STATUS 8'h0c
`define OFS_ACTPOS 8'h10
`define OFS_STORED_POINT_TYPE 8'h20
`define OFS_MAXVEL 8'h30
`define OFS_ACCEL 8'h40
`define OFS_TVEL 8'h50
`define OFS_TPOS 8'h60

// Reset values
`define RST_MODADDR 8'h01
`define RST_MAXVEL 32'h0000c800
`define RST_ACCEL 32'h00001000

`endif

// >>> include/motion_pkg.sv
// Types shared by the motion command interpreter and its surroundings.
// Assumes the constants header is included by the users of this package.
package motion_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic {st_collect, st_exec} fsm_e;

   // Command set handed to one axis's ramp generator
   typedef struct packed {
      logic pos_mode;
      logic [31:0] target_vel;
      logic [31:0] target_pos;
      logic [31:0] max_vel;
      logic [31:0] accel;
   } axis_cmd_s;

   // Reply to the host
   typedef struct packed {
      byte_t status;
      byte_t code;
      logic [31:0] value;
   } reply_s;

endpackage : motion_pkg

// >>> rtl/motion_cmd_exec.sv
// Motion command interpreter for three axes, accumulator and X register forms.
// Assumes byte stream inputs synchronous to mclk and an external ramp
// generator per axis that reports its actual position.
//
// How it works
// [R1] Left spin: velocity mode, target velocity is the negated accumulator.
// [R2] Right spin: velocity mode, target velocity is the accumulator.
// [R3] Velocity values are step pulses per second, passed on unscaled.
// [R4] Spins set velocity mode, then write the target velocity parameter.
// [R5] Code 50 spins left, axis from motor field 0..2.
// [R6] Code 51 spins right, axis from motor field 0..2.
// [R7] Code 52 ignores type, motor and value fields.
// [R8] Code 52 takes its axis from the X register.
// [R9] Code 47 moves; type 0 fixed, 1 offset, 2 stored point.
// [R10] Code 47 type 0 copies accumulator into target position of axis X.
// [R11] Offset type adds accumulator to the actual position.
// [R12] Stored point type moves to the axis's saved coordinate.
// [R13] Reply follows setup at once; new frames accepted during motion.
// [R14] Ramp limits come from per-axis configuration registers.
// [R15] Halt or spin commands abort a move in progress.
// [R16] Host keeps move distance within 2^31-1; sums simply wrap.
// [R17] Frame: address, code, type, motor, value MSB first, checksum.
// [R18] Checksum is modulo-256 sum of eight bytes; mismatches are rejected.
// [R19] Accepted instructions reply status 100.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "motion_defines.svh"

module motion_cmd_exec
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire motion_pkg::byte_t rx_byte,
   output motion_pkg::axis_cmd_s [2:0] axis_cmd,
   output logic [2:0] axis_load,
   output logic rx_ready,
   output logic reply_valid,
   output motion_pkg::reply_s reply,
   input wire logic [95:0] act_pos,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata
);
   import motion_pkg::*;

   function automatic byte_t frame_sum(input byte_t f [0:8]);
      byte_t s;
      s = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         s = s + f[i];
      end
      return s;
   endfunction : frame_sum

   function automatic logic axis_valid(input logic [31:0] sel);
      return sel < 32'(`AXES);
   endfunction : axis_valid

   fsm_e state_q;
   byte_t frame_q [0:8];
   logic [3:0] idx_q;
   logic rx_ready_q;
   logic [31:0] accu_q;
   logic [31:0] x_q;
   byte_t modaddr_q;
   logic [31:0] stored_point_type_q [0:2];
   axis_cmd_s [2:0] axis_q;
   logic [2:0] load_q;
   logic reply_valid_q;
   reply_s reply_q;
   byte_t last_status_q;
   logic [31:0] rdata_q;

   byte_t code;
   byte_t mtype;
   logic [31:0] value;
   logic sum_ok;
   logic for_us;
   logic use_x;
   logic [31:0] sel;
   logic [1:0] ax;
   byte_t status_d;
   logic go;

   // Field extraction and decode of the held frame
   always_comb
   begin
      code = frame_q[`FB_CODE];
      mtype = frame_q[`FB_TYPE];
      value = {frame_q[4], frame_q[5], frame_q[6], frame_q[7]}; // see [R17]
      sum_ok = frame_sum(frame_q) == frame_q[`FB_SUM]; // see [R18]
      for_us = frame_q[`FB_ADDR] == modaddr_q;
      use_x = code == `CODE_LEFT_IDX || code == `CODE_GOTO_IDX; // see [R8]
      sel = use_x ? x_q : {24'h0, frame_q[`FB_MOTOR]}; // see [R5] see [R6]
      ax = sel[1:0];
      if (!sum_ok)
      begin
         status_d = `ST_BAD_SUM; // see [R18]
      end
      else
      begin
         case (code)
            `CODE_SPIN_RIGHT, `CODE_SPIN_LEFT, `CODE_HALT, `CODE_LEFT_ACCU,
            `CODE_RIGHT_ACCU, `CODE_LEFT_IDX:
               status_d = axis_valid(sel) ? `ST_OK : `ST_BAD_VALUE; // see [R7]
            `CODE_GOTO_IDX:
               if (mtype > `TYPE_STORED)
               begin
                  status_d = `ST_BAD_TYPE; // see [R9]
               end
               else
               begin
                  status_d = axis_valid(sel) ? `ST_OK : `ST_BAD_VALUE;
               end
            default:
               status_d = `ST_BAD_CMD;
         endcase
      end
      go = state_q == st_exec && for_us && status_d == `ST_OK;
   end

   // Frame collection
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         idx_q <= 4'h0;
         for (int i = 0; i < 9; i++)
         begin
            frame_q[i] <= 8'h00;
         end
      end
      else if (rx_valid && rx_ready_q)
      begin
         frame_q[idx_q] <= rx_byte; // see [R17]
         idx_q <= (idx_q == `FRAME_LAST) ? 4'h0 : idx_q + 4'h1;
      end
   end

   // Sequencer: collect nine bytes, then one execute cycle
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= st_collect;
         rx_ready_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            st_collect:
            begin
               rx_ready_q <= 1'b1;
               if (rx_valid && rx_ready_q && idx_q == `FRAME_LAST)
               begin
                  state_q <= st_exec;
                  rx_ready_q <= 1'b0;
               end
            end
            st_exec:
            begin
               state_q <= st_collect; // see [R13]
               rx_ready_q <= 1'b1;
            end
            default:
               state_q <= st_collect;
         endcase
      end
   end

   // Axis command registers
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         load_q <= 3'h0;
         for (int a = 0; a < 3; a++)
         begin
            axis_q[a] <= '{1'b0, 32'h0, 32'h0, `RST_MAXVEL, `RST_ACCEL};
         end
      end
      else
      begin
         load_q <= 3'h0;
         for (int a = 0; a < 3; a++)
         begin
            if (bus_wr && bus_addr == `OFS_MAXVEL + 8'(4 * a))
            begin
               axis_q[a].max_vel <= bus_wdata; // see [R14]
            end
            if (bus_wr && bus_addr == `OFS_ACCEL + 8'(4 * a))
            begin
               axis_q[a].accel <= bus_wdata; // see [R14]
            end
         end
         if (go)
         begin
            load_q[ax] <= 1'b1;
            case (code)
               `CODE_LEFT_ACCU, `CODE_LEFT_IDX:
               begin
                  axis_q[ax].pos_mode <= 1'b0; // see [R4] see [R15]
                  axis_q[ax].target_vel <= 32'h0 - accu_q; // see [R1] see [R3]
               end
               `CODE_RIGHT_ACCU:
               begin
                  axis_q[ax].pos_mode <= 1'b0; // see [R4] see [R15]
                  axis_q[ax].target_vel <= accu_q; // see [R2] see [R3]
               end
               `CODE_SPIN_LEFT:
               begin
                  axis_q[ax].pos_mode <= 1'b0; // see [R15]
                  axis_q[ax].target_vel <= 32'h0 - value;
               end
               `CODE_SPIN_RIGHT:
               begin
                  axis_q[ax].pos_mode <= 1'b0; // see [R15]
                  axis_q[ax].target_vel <= value;
               end
               `CODE_HALT:
               begin
                  axis_q[ax].pos_mode <= 1'b0; // see [R15]
                  axis_q[ax].target_vel <= 32'h0;
               end
               `CODE_GOTO_IDX:
               begin
                  axis_q[ax].pos_mode <= 1'b1;
                  case (mtype)
                     `TYPE_FIXED:
                        axis_q[ax].target_pos <= accu_q; // see [R10]
                     `TYPE_OFFSET:
                        axis_q[ax].target_pos <= act_pos[32 * ax +: 32] + accu_q; // see [R11] see [R16]
                     default:
                        axis_q[ax].target_pos <= stored_point_type_q[ax]; // see [R12]
                  endcase
               end
               default:
                  load_q[ax] <= 1'b0;
            endcase
         end
      end
   end

   // Reply generation
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reply_valid_q <= 1'b0;
         reply_q <= '0;
         last_status_q <= 8'h00;
      end
      else
      begin
         reply_valid_q <= 1'b0;
         if (state_q == st_exec && (for_us || !sum_ok))
         begin
            reply_valid_q <= 1'b1; // see [R13]
            reply_q <= '{status_d, code, accu_q}; // see [R19]
            last_status_q <= status_d;
         end
      end
   end

   // Software registers: accumulator, X register, address, coordinates
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         accu_q <= 32'h0;
         x_q <= 32'h0;
         modaddr_q <= `RST_MODADDR;
         for (int a = 0; a < 3; a++)
         begin
            stored_point_type_q[a] <= 32'h0;
         end
      end
      else if (bus_wr)
      begin
         case (bus_addr)
            `OFS_ACCU: accu_q <= bus_wdata;
            `OFS_XREG: x_q <= bus_wdata;
            `OFS_MODADDR: modaddr_q <= bus_wdata[7:0];
            default:
               for (int a = 0; a < 3; a++)
               begin
                  if (bus_addr == `OFS_STORED_POINT_TYPE + 8'(4 * a))
                  begin
                     stored_point_type_q[a] <= bus_wdata;
                  end
               end
         endcase
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_q <= 32'h0;
      end
      else if (bus_rd)
      begin
         rdata_q <= 32'h0;
         case (bus_addr)
            `OFS_ACCU: rdata_q <= accu_q;
            `OFS_XREG: rdata_q <= x_q;
            `OFS_MODADDR: rdata_q <= {24'h0, modaddr_q};
            `OFS_STATUS:
               rdata_q <= {20'h0, axis_q[2].pos_mode, axis_q[1].pos_mode,
                  axis_q[0].pos_mode, state_q == st_exec, last_status_q};
            default:
               for (int a = 0; a < 3; a++)
               begin
                  if (bus_addr == `OFS_ACTPOS + 8'(4 * a))
                     rdata_q <= act_pos[32 * a +: 32];
                  if (bus_addr == `OFS_STORED_POINT_TYPE + 8'(4 * a))
                     rdata_q <= stored_point_type_q[a];
                  if (bus_addr == `OFS_MAXVEL + 8'(4 * a))
                     rdata_q <= axis_q[a].max_vel;
                  if (bus_addr == `OFS_ACCEL + 8'(4 * a))
                     rdata_q <= axis_q[a].accel;
                  if (bus_addr == `OFS_TVEL + 8'(4 * a))
                     rdata_q <= axis_q[a].target_vel;
                  if (bus_addr == `OFS_TPOS + 8'(4 * a))
                     rdata_q <= axis_q[a].target_pos;
               end
         endcase
      end
   end

   assign axis_cmd = axis_q;
   assign axis_load = load_q;
   assign rx_ready = rx_ready_q;
   assign reply_valid = reply_valid_q;
   assign reply = reply_q;
   assign bus_rdata = rdata_q;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_go(logic [7:0] c);
      go && code == c;
   endsequence

   sequence s_reply_ok;
      reply_valid ##0 reply.status == `ST_OK ##1 !reply_valid;
   endsequence

   AST_LEFT_ACCU: assert property (s_go(`CODE_LEFT_ACCU) |=> // see [R1]
      !axis_q[$past(ax)].pos_mode && axis_q[$past(ax)].target_vel == 32'h0 - $past(accu_q))
      else $error("left spin velocity wrong");
   AST_RIGHT_ACCU: assert property (s_go(`CODE_RIGHT_ACCU) |=> // see [R2]
      !axis_q[$past(ax)].pos_mode && axis_q[$past(ax)].target_vel == $past(accu_q))
      else $error("right spin velocity wrong");
   AST_LEFT_IDX: assert property (s_go(`CODE_LEFT_IDX) |=> // see [R8]
      axis_load[$past(x_q[1:0])] && axis_q[$past(x_q[1:0])].target_vel == 32'h0 - $past(accu_q))
      else $error("indexed spin went to wrong axis");
   AST_GOTO_FIXED: assert property (s_go(`CODE_GOTO_IDX) ##0 mtype == `TYPE_FIXED |=> // see [R10]
      axis_q[$past(x_q[1:0])].pos_mode && axis_q[$past(x_q[1:0])].target_pos == $past(accu_q))
      else $error("fixed move target wrong");
   AST_GOTO_OFFSET: assert property (s_go(`CODE_GOTO_IDX) ##0 mtype == `TYPE_OFFSET |=> // see [R11]
      axis_q[$past(ax)].target_pos == $past(act_pos[32 * ax +: 32]) + $past(accu_q))
      else $error("offset move target wrong");
   AST_GOTO_STORED: assert property (s_go(`CODE_GOTO_IDX) ##0 mtype == `TYPE_STORED |=> // see [R12]
      axis_q[$past(ax)].target_pos == $past(stored_point_type_q[ax]))
      else $error("stored point move target wrong");
   AST_HALT: assert property (s_go(`CODE_HALT) |=> // see [R15]
      !axis_q[$past(ax)].pos_mode && axis_q[$past(ax)].target_vel == 32'h0)
      else $error("halt did not stop axis");
   AST_REPLY: assert property (go |=> s_reply_ok ##0 rx_ready) // see [R13]
      else $error("reply not issued one cycle after execution");
   AST_BAD_SUM: assert property (state_q == st_exec && !sum_ok |=> // see [R18]
      reply_valid && reply.status == `ST_BAD_SUM && axis_load == 3'h0)
      else $error("bad checksum not rejected");

endmodule : motion_cmd_exec

// >>> dv/host_model.sv
// Host model: sends nine-byte command frames over the byte handshake.
// Assumes one rising-edge clock shared with the interpreter.
`timescale 1ns/1ps

module host_model
(
   input wire logic mclk,
   input wire logic rx_ready,
   output logic rx_valid,
   output motion_pkg::byte_t rx_byte
);
   import motion_pkg::*;

   initial
   begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end

   // Gap idles before each byte for a slow host; bad spoils the checksum
   task automatic send(input logic [31:0] hdr, input logic [31:0] val, input logic bad,
                       input int gap, output logic ok);
      logic [71:0] fr;
      byte_t sum;
      logic rdy;
      int guard;
      sum = 8'h00;
      for (int i = 0; i < 4; i++)
      begin
         sum += hdr[8*i +: 8] + val[8*i +: 8];
      end
      fr = {hdr, val, bad ? ~sum : sum};
      ok = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         repeat (gap)
         begin
            rx_valid <= 1'b0;
            rx_byte <= ~rx_byte;
            @(posedge mclk);
         end
         rx_valid <= 1'b1;
         rx_byte <= fr[71 - 8*i -: 8];
         guard = 0;
         do
         begin
            @(negedge mclk);
            rdy = rx_ready;
            @(posedge mclk);
            guard++;
         end
         while (rdy !== 1'b1 && guard < 20);
         if (rdy !== 1'b1)
            ok = 1'b0;
      end
      rx_valid <= 1'b0;
      rx_byte <= ~fr[7:0];
   endtask : send

endmodule : host_model

// >>> dv/test_motion_command_accu_exec.sv
// Testbench of the motion command interpreter: frames, register port, axis outputs.
// Assumes the host model drives the byte link; actual positions are driven here.
`timescale 1ns/1ps
`include "motion_defines.svh"

module test_motion_command_accu_exec;
   import motion_pkg::*;

   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic rx_valid, rx_ready, reply_valid;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   byte_t rx_byte;
   axis_cmd_s [2:0] axis_cmd;
   logic [2:0] axis_load, load_seen;
   reply_s reply;
   logic [95:0] act_pos = '0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = '0;
   logic [31:0] bus_rdata, rd;
   byte_t abort [3] = '{`CODE_SPIN_RIGHT, `CODE_SPIN_LEFT, `CODE_HALT};
   int fail_count = 0;
   int n_checks = 0;

   always #2 mclk = ~mclk;

   motion_cmd_exec dut_u
   (
      .mclk(mclk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .axis_cmd(axis_cmd), .axis_load(axis_load), .rx_ready(rx_ready),
      .reply_valid(reply_valid), .reply(reply), .act_pos(act_pos),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata)
   );

   host_model host_u
   (
      .mclk(mclk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte)
   );

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      @(posedge mclk);
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      d = bus_rdata;
      @(posedge mclk);
   endtask : bus_read

   // Sends one frame and compares the reply and the axis load pulse
   task automatic run(input logic [31:0] hdr, input logic [31:0] val, input logic bad,
                      input int gap, input logic want, input byte_t st, input logic [2:0] ld);
      logic ok;
      logic got;
      host_u.send(hdr, val, bad, gap, ok);
      if (ok !== 1'b1)
      begin
         fail_count++;
         tally_and_finish();
      end
      got = 1'b0;
      load_seen = 3'b000;
      repeat (3)
      begin
         @(negedge mclk);
         if (reply_valid === 1'b1)
         begin
            got = 1'b1;
            load_seen = axis_load;
         end
         @(posedge mclk);
      end
      check("reply present", got, want);
      if (want)
         check("status", reply.status, st);
      if (want && st == `ST_OK)
         check("code", reply.code, hdr[23:16]);
      check("axis load", load_seen, ld);
   endtask : run

   initial
   begin
      repeat (6) @(posedge mclk);
      check("ready in reset", rx_ready, 1'b0);
      check("reset max vel", axis_cmd[2].max_vel, `RST_MAXVEL);
      check("reset accel", axis_cmd[2].accel, `RST_ACCEL);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      bus_read(`OFS_MODADDR, rd);
      check("module address", rd, 32'h1);
      bus_read(8'hfc, rd);
      check("unmapped read", rd, 32'h0);
      // Accumulator spins with junk in the ignored fields
      bus_write(`OFS_ACCU, 32'd100);
      run({`RST_MODADDR, `CODE_LEFT_ACCU, 8'h07, 8'h01}, 32'h5a5a5a5a, 0, 0, 1, `ST_OK, 3'b010);
      check("left mode", axis_cmd[1].pos_mode, 1'b0);
      check("left vel", axis_cmd[1].target_vel, 32'hffffff9c);
      bus_read(`OFS_TVEL + 8'h04, rd);
      check("vel param", rd, 32'hffffff9c);
      bus_write(`OFS_ACCU, 32'h00012345);
      run({`RST_MODADDR, `CODE_RIGHT_ACCU, 8'h03, 8'h02}, 32'h1, 0, 2, 1, `ST_OK, 3'b100);
      check("right vel", axis_cmd[2].target_vel, 32'h00012345);
      bus_write(`OFS_XREG, 32'h0);
      run({`RST_MODADDR, `CODE_LEFT_IDX, 8'h05, 8'h02}, 32'h77, 0, 0, 1, `ST_OK, 3'b001);
      check("index vel", axis_cmd[0].target_vel, 32'hfffedcbb);
      // Moves on the axis named by the X register
      bus_write(`OFS_MAXVEL + 8'h04, 32'h777);
      bus_write(`OFS_ACCEL + 8'h04, 32'h55);
      bus_write(`OFS_XREG, 32'h1);
      bus_write(`OFS_ACCU, 32'd1000);
      run({`RST_MODADDR, `CODE_GOTO_IDX, `TYPE_FIXED, 8'h02}, 32'h9, 0, 0, 1, `ST_OK, 3'b010);
      check("move mode", axis_cmd[1].pos_mode, 1'b1);
      check("move pos", axis_cmd[1].target_pos, 32'd1000);
      check("move vel lim", axis_cmd[1].max_vel, 32'h777);
      check("move accel", axis_cmd[1].accel, 32'h55);
      // Distance across the wrap stays small
      act_pos[63:32] <= 32'hffffff00;
      bus_write(`OFS_ACCU, 32'h200);
      run({`RST_MODADDR, `CODE_GOTO_IDX, `TYPE_OFFSET, 8'h00}, 32'h0, 0, 0, 1, `ST_OK, 3'b010);
      check("offset pos", axis_cmd[1].target_pos, 32'h100);
      bus_write(`OFS_STORED_POINT_TYPE + 8'h08, 32'h1234);
      bus_write(`OFS_XREG, 32'h2);
      run({`RST_MODADDR, `CODE_GOTO_IDX, `TYPE_STORED, 8'h01}, 32'h0, 0, 0, 1, `ST_OK, 3'b100);
      check("stored pos", axis_cmd[2].target_pos, 32'h1234);
      bus_write(`OFS_XREG, 32'h1);
      foreach (abort[i])
      begin
         run({`RST_MODADDR, `CODE_GOTO_IDX, `TYPE_FIXED, 8'h00}, 32'h0, 0, 0, 1, `ST_OK, 3'b010);
         run({`RST_MODADDR, abort[i], 8'h00, 8'h01}, 32'h0, 0, 0, 1, `ST_OK, 3'b010);
         check("abort mode", axis_cmd[1].pos_mode, 1'b0);
      end
      check("halt vel", axis_cmd[1].target_vel, 32'h0);
      // Refused frames leave every axis alone
      run({`RST_MODADDR, `CODE_LEFT_ACCU, 8'h00, 8'h00}, 32'h0, 1, 0, 1, `ST_BAD_SUM, 3'b000);
      run({8'h05, `CODE_LEFT_ACCU, 8'h00, 8'h00}, 32'h0, 0, 0, 0, `ST_OK, 3'b000);
      run({`RST_MODADDR, 8'h35, 8'h00, 8'h00}, 32'h0, 0, 0, 1, `ST_BAD_CMD, 3'b000);
      run({`RST_MODADDR, `CODE_GOTO_IDX, 8'h03, 8'h00}, 32'h0, 0, 0, 1, `ST_BAD_TYPE, 3'b000);
      run({`RST_MODADDR, `CODE_RIGHT_ACCU, 8'h00, 8'h03}, 32'h0, 0, 0, 1, `ST_BAD_VALUE, 3'b000);
      bus_write(`OFS_XREG, 32'h3);
      run({`RST_MODADDR, `CODE_LEFT_IDX, 8'h00, 8'h00}, 32'h0, 0, 0, 1, `ST_BAD_VALUE, 3'b000);
      // Axis 2 still in position mode, last status the value error
      bus_read(`OFS_STATUS, rd);
      check("status reg", rd, 32'h00000804);
      tally_and_finish();
   end

endmodule : test_motion_command_accu_exec
